// ---- shared/pfc_cfg.svh ----
// constants for the processor thermal configuration register bank
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

// register indices, byte address is four times the index
`define PFC_IDX_REMOTE1     8'h25
`define PFC_IDX_CPU_READING 8'h33
`define PFC_IDX_CPU_CFG     8'h36
`define PFC_IDX_DUTY1       8'h38
`define PFC_IDX_DUTY2       8'h39
`define PFC_IDX_DUTY3       8'h3A
`define PFC_IDX_START_THR   8'h3B
`define PFC_IDX_GEN_CFG1    8'h40

// reset values
`define PFC_RST_CPU_CFG     8'h00
`define PFC_RST_DUTY        8'hFF
`define PFC_RST_START_THR   8'hE0
`define PFC_RST_READING     8'h80
`define PFC_RST_GEN_CFG1    8'h00

// field positions
`define PFC_CFG_AVG_LSB     0
`define PFC_CFG_AVG_MSB     2
`define PFC_CFG_DOM_BIT     3
`define PFC_CFG_SWAP_BIT    4
`define PFC_CFG_USED_MASK   8'h1F
`define PFC_GEN_LOCK_BIT    1
`define PFC_AVG_RESERVED    3'h7

// timing
`define PFC_BITS_PER_READ   67
`define PFC_IDLE_GAP_NS     14000
`define PFC_CLK_PERIOD_NS   10
`define PFC_IDLE_CYCLES     ((`PFC_IDLE_GAP_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)

`endif

// ---- shared/pfc_pkg.sv ----
// types for the processor thermal configuration register bank
package pfc_pkg;
   typedef enum logic [0:0] {
      PFC_BITS = 1'b0,
      PFC_GAP = 1'b1
   } pfc_phase_e;
endpackage : pfc_pkg

// ---- verilog/pfc_regs.sv ----
// processor thermal configuration and fan limit register bank with apb slave
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`include "pfc_cfg.svh"

// Overview of operation
// - averaging code 000..110 selects 16,2048..65536 readings; 111 reserved
// - processor result register updates once per smoothing interval
// - each reading 67 bit times per cpu; interval is readings times cycle length
// - a 14 us idle gap follows each read cycle and counts in the interval
// - bit 3 flags single (0) or dual (1) domain first cpu
// - bit 4 swaps remote-1 and first processor reading registers
// - swap also moves the processor start request from cpu_fan_start to remote1_fan_start
// - lock bit makes configuration and limit registers ignore writes
// - three duty ceilings cap their fan drives, reset 0xFF
// - measurement above start threshold requests fan start at minimum duty
// - start threshold resets to 0xE0, -32 degrees
// - processor configuration resets to 0x00
// - first processor reading register returns the eight bit client value
module pfc_regs #(
   parameter int BIT_CYC_W = 16,
   parameter int CYC_CNT_W = 32
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [BIT_CYC_W-1:0] cpu_bit_cycles,
   input wire logic [1:0] cpu_count_minus1,
   input wire logic [7:0] cpu_sample,
   input wire logic [7:0] remote1_temp,
   input wire logic [7:0] fan_drive_1_request,
   input wire logic [7:0] fan_drive_2_request,
   input wire logic [7:0] fan_drive_3_request,
   output logic [7:0] fan_drive_1,
   output logic [7:0] fan_drive_2,
   output logic [7:0] fan_drive_3,
   output logic cpu1_domain_count,
   output logic swap_active,
   output logic cpu_read_start,
   output logic cpu_fan_start,
   output logic remote1_fan_start,
   output logic reading_update
);

   // ---------------------------------------------------------------
   // register storage
   // ---------------------------------------------------------------
   logic [4:0] cpu_cfg_reg;
   logic [7:0] duty_ceiling_reg [3];
   logic [7:0] start_thr_reg;
   logic lock_reg;
   logic [2:0] avg_eff_reg;
   logic [7:0] first_cpu_reading_reg;
   logic [31:0] prdata_reg;
   logic err_reg;
   logic [7:0] fan_drive_reg [3];

   logic [7:0] idx;
   logic setup;
   logic wr_en;
   logic [7:0] wbyte;
   logic [7:0] req [3];

   assign idx = paddr[9:2];
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && !lock_reg;
   assign wbyte = pwdata[7:0];
   assign req[0] = fan_drive_1_request;
   assign req[1] = fan_drive_2_request;
   assign req[2] = fan_drive_3_request;

   // swapped views of the two exchanged channels
   logic [7:0] remote1_view;
   logic [7:0] cpu_view;
   assign remote1_view = cpu_cfg_reg[`PFC_CFG_SWAP_BIT] ? first_cpu_reading_reg
                                                          : remote1_temp;
   assign cpu_view = cpu_cfg_reg[`PFC_CFG_SWAP_BIT] ? remote1_temp
                                                      : first_cpu_reading_reg;

   // ---------------------------------------------------------------
   // processor configuration
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cpu_cfg_reg <= 5'(`PFC_RST_CPU_CFG);
      end else if (wr_en && idx == `PFC_IDX_CPU_CFG) begin
         cpu_cfg_reg <= wbyte[4:0];
      end
   end

   // reserved averaging code leaves the active selection unchanged
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         avg_eff_reg <= 3'h0;
      end else if (cpu_cfg_reg[`PFC_CFG_AVG_MSB:`PFC_CFG_AVG_LSB] != `PFC_AVG_RESERVED) begin
         avg_eff_reg <= cpu_cfg_reg[`PFC_CFG_AVG_MSB:`PFC_CFG_AVG_LSB];
      end
   end

   assign cpu1_domain_count = cpu_cfg_reg[`PFC_CFG_DOM_BIT];
   assign swap_active = cpu_cfg_reg[`PFC_CFG_SWAP_BIT];

   // ---------------------------------------------------------------
   // lock and start threshold
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         lock_reg <= 1'b0;
      end else if (psel && penable && pwrite && idx == `PFC_IDX_GEN_CFG1
                   && pwdata[`PFC_GEN_LOCK_BIT]) begin
         lock_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         start_thr_reg <= `PFC_RST_START_THR;
      end else if (wr_en && idx == `PFC_IDX_START_THR) begin
         start_thr_reg <= wbyte;
      end
   end

   // ---------------------------------------------------------------
   // duty ceilings and capped fan drives
   // ---------------------------------------------------------------
   for (genvar g = 0; g < 3; g++) begin : g_fan
      always_ff @(posedge sys_clk or negedge rstn) begin
         if (!rstn) begin
            duty_ceiling_reg[g] <= `PFC_RST_DUTY;
         end else if (wr_en && idx == 8'(`PFC_IDX_DUTY1 + g)) begin
            duty_ceiling_reg[g] <= wbyte;
         end
      end

      always_ff @(posedge sys_clk or negedge rstn) begin
         if (!rstn) begin
            fan_drive_reg[g] <= `PFC_RST_DUTY;
         end else if (req[g] > duty_ceiling_reg[g]) begin
            fan_drive_reg[g] <= duty_ceiling_reg[g];
         end else begin
            fan_drive_reg[g] <= req[g];
         end
      end
   end

   assign fan_drive_1 = fan_drive_reg[0];
   assign fan_drive_2 = fan_drive_reg[1];
   assign fan_drive_3 = fan_drive_reg[2];

   // ---------------------------------------------------------------
   // automatic control start comparison
   // ---------------------------------------------------------------
   logic cpu_fan_start_reg;
   logic remote1_fan_start_reg;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cpu_fan_start_reg <= 1'b0;
         remote1_fan_start_reg <= 1'b0;
      end else begin
         // threshold follows whichever channel holds the processor data
         cpu_fan_start_reg <= $signed(cpu_view) > $signed(start_thr_reg) &&
                              !cpu_cfg_reg[`PFC_CFG_SWAP_BIT];
         remote1_fan_start_reg <= $signed(remote1_view) > $signed(start_thr_reg) &&
                                  cpu_cfg_reg[`PFC_CFG_SWAP_BIT];
      end
   end
   assign cpu_fan_start = cpu_fan_start_reg;
   assign remote1_fan_start = remote1_fan_start_reg;

   // ---------------------------------------------------------------
   // read cycle timing
   // ---------------------------------------------------------------
   pfc_pkg::pfc_phase_e phase_reg;
   logic [CYC_CNT_W-1:0] cyc_cnt_reg;
   logic [CYC_CNT_W-1:0] bits_len;
   logic [CYC_CNT_W-1:0] gap_len;
   logic cycle_end;

   assign bits_len = CYC_CNT_W'(`PFC_BITS_PER_READ) * CYC_CNT_W'(cpu_bit_cycles)
                     * (CYC_CNT_W'(cpu_count_minus1) + CYC_CNT_W'(1));
   assign gap_len = CYC_CNT_W'(`PFC_IDLE_CYCLES);
   assign cycle_end = phase_reg == pfc_pkg::PFC_GAP && cyc_cnt_reg >= gap_len - 1'b1;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         phase_reg <= pfc_pkg::PFC_BITS;
         cyc_cnt_reg <= '0;
      end else begin
         case (phase_reg)
            pfc_pkg::PFC_BITS: begin
               if (cyc_cnt_reg >= bits_len - 1'b1) begin
                  phase_reg <= pfc_pkg::PFC_GAP;
                  cyc_cnt_reg <= '0;
               end else begin
                  cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
               end
            end
            pfc_pkg::PFC_GAP: begin
               if (cycle_end) begin
                  phase_reg <= pfc_pkg::PFC_BITS;
                  cyc_cnt_reg <= '0;
               end else begin
                  cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
               end
            end
            default: begin
               phase_reg <= pfc_pkg::PFC_BITS;
               cyc_cnt_reg <= '0;
            end
         endcase
      end
   end

   assign cpu_read_start = phase_reg == pfc_pkg::PFC_BITS && cyc_cnt_reg == '0;

   // ---------------------------------------------------------------
   // smoothing accumulator
   // ---------------------------------------------------------------
   logic [16:0] read_cnt_reg;
   logic signed [24:0] acc_reg;
   logic signed [24:0] acc_sum;
   logic [16:0] read_target;
   logic [4:0] avg_shift;
   logic upd_reg;

   always_comb begin
      read_target = 17'h00010;
      avg_shift = 5'h04;
      case (avg_eff_reg)
         3'h0: begin read_target = 17'h00010; avg_shift = 5'h04; end
         3'h1: begin read_target = 17'h00800; avg_shift = 5'h0B; end
         3'h2: begin read_target = 17'h01000; avg_shift = 5'h0C; end
         3'h3: begin read_target = 17'h02000; avg_shift = 5'h0D; end
         3'h4: begin read_target = 17'h04000; avg_shift = 5'h0E; end
         3'h5: begin read_target = 17'h08000; avg_shift = 5'h0F; end
         3'h6: begin read_target = 17'h10000; avg_shift = 5'h10; end
         default: begin read_target = 17'h00010; avg_shift = 5'h04; end
      endcase
   end

   assign acc_sum = acc_reg + 25'(signed'(cpu_sample));

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         read_cnt_reg <= '0;
         acc_reg <= '0;
         first_cpu_reading_reg <= `PFC_RST_READING;
         upd_reg <= 1'b0;
      end else begin
         upd_reg <= 1'b0;
         if (cycle_end) begin
            if (read_cnt_reg >= read_target - 1'b1) begin
               first_cpu_reading_reg <= 8'(acc_sum >>> avg_shift);
               acc_reg <= '0;
               read_cnt_reg <= '0;
               upd_reg <= 1'b1;
            end else begin
               acc_reg <= acc_sum;
               read_cnt_reg <= read_cnt_reg + 1'b1;
            end
         end
      end
   end
   assign reading_update = upd_reg;

   // ---------------------------------------------------------------
   // apb read path
   // ---------------------------------------------------------------
   logic [7:0] rd_byte;
   logic hit;
   always_comb begin
      rd_byte = 8'h00;
      hit = 1'b1;
      case (idx)
         `PFC_IDX_REMOTE1: rd_byte = remote1_view;
         `PFC_IDX_CPU_READING: rd_byte = cpu_view;
         `PFC_IDX_CPU_CFG: rd_byte = {3'h0, cpu_cfg_reg};
         `PFC_IDX_DUTY1: rd_byte = duty_ceiling_reg[0];
         `PFC_IDX_DUTY2: rd_byte = duty_ceiling_reg[1];
         `PFC_IDX_DUTY3: rd_byte = duty_ceiling_reg[2];
         `PFC_IDX_START_THR: rd_byte = start_thr_reg;
         `PFC_IDX_GEN_CFG1: rd_byte = 8'(lock_reg) << `PFC_GEN_LOCK_BIT;
         default: hit = 1'b0;
      endcase
      if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
         hit = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata_reg <= '0;
         err_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= hit ? {24'h000000, rd_byte} : 32'h00000000;
         err_reg <= !hit;
      end
   end

   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = psel && penable && err_reg;

endmodule : pfc_regs

// ---- test/pfc_regs_properties.sv ----
// assertion checker for the processor thermal configuration register bank
`timescale 1ns/100ps
module pfc_regs_properties #(
   parameter int BIT_CYC_W = 16,
   parameter int CYC_CNT_W = 32
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic [BIT_CYC_W-1:0] cpu_bit_cycles,
   input wire logic [1:0] cpu_count_minus1,
   input wire logic [7:0] fan_drive_1_request,
   input wire logic [7:0] fan_drive_1,
   input wire logic cpu1_domain_count,
   input wire logic swap_active,
   input wire logic cpu_read_start,
   input wire logic cpu_fan_start,
   input wire logic remote1_fan_start,
   input wire logic reading_update
);
   localparam int GAP = 1400;
   logic [31:0] gap_cnt;
   logic seen;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // ----------------------------------------
   // cycles since the last read cycle start
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gap_cnt <= 32'h0;
         seen <= 1'b0;
      end else if (cpu_read_start) begin
         gap_cnt <= 32'h0;
         seen <= 1'b1;
      end else begin
         gap_cnt <= gap_cnt + 32'h1;
      end
   end
   property p_read_gap;
      cpu_read_start && seen |->
         gap_cnt == 32'(67 * cpu_bit_cycles * (cpu_count_minus1 + 1) + GAP - 1);
   endproperty
   a_read_gap: assert property (p_read_gap) else $error("read cycle period wrong");
   property p_start_pulse;
      cpu_read_start |=> !cpu_read_start [*8];
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("read start too long");
   property p_update_pulse;
      reading_update |=> !reading_update [*8];
   endproperty
   a_update_pulse: assert property (p_update_pulse) else $error("update pulse too long");
   property p_dom;
      $changed(cpu1_domain_count) |-> $past(psel && penable && pwrite && paddr == 12'h0D8);
   endproperty
   a_dom: assert property (p_dom) else $error("domain flag moved without write");
   property p_swap;
      $changed(swap_active) |-> $past(psel && penable && pwrite && paddr == 12'h0D8);
   endproperty
   a_swap: assert property (p_swap) else $error("swap flag moved without write");
   property p_cpu_fan;
      $past(swap_active) |-> !cpu_fan_start;
   endproperty
   a_cpu_fan: assert property (p_cpu_fan) else $error("cpu fan start while swapped");
   property p_rem_fan;
      !$past(swap_active) |-> !remote1_fan_start;
   endproperty
   a_rem_fan: assert property (p_rem_fan) else $error("remote fan start unswapped");
   property p_duty1;
      $past(rstn) |-> fan_drive_1 <= $past(fan_drive_1_request);
   endproperty
   a_duty1: assert property (p_duty1) else $error("drive above request");
   property p_reserved;
      psel && penable && !pwrite && paddr == 12'h0D8 |-> prdata[31:5] == 27'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule : pfc_regs_properties
bind pfc_regs pfc_regs_properties #(.BIT_CYC_W(BIT_CYC_W), .CYC_CNT_W(CYC_CNT_W)) u_props (
   .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .cpu_bit_cycles(cpu_bit_cycles),
   .cpu_count_minus1(cpu_count_minus1), .fan_drive_1_request(fan_drive_1_request),
   .fan_drive_1(fan_drive_1), .cpu1_domain_count(cpu1_domain_count),
   .swap_active(swap_active), .cpu_read_start(cpu_read_start), .cpu_fan_start(cpu_fan_start),
   .remote1_fan_start(remote1_fan_start), .reading_update(reading_update));

// ---- test/pfc_regs_tb.sv ----
// self-checking bench for the processor thermal configuration register bank
`timescale 1ns/100ps
`include "pfc_cfg.svh"
module pfc_regs_tb;
   logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] req [3];
   logic [7:0] fd [3];
   logic dom, swp, crs, cfs, rfs, upd;
   logic [15:0] bitc;
   logic [1:0] ncpu;
   int n_errors, tests_run, cyc, n;
   pfc_regs dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_bit_cycles(bitc), .cpu_count_minus1(ncpu),
      .cpu_sample(8'hF6), .remote1_temp(8'h2A), .fan_drive_1_request(req[0]),
      .fan_drive_2_request(req[1]), .fan_drive_3_request(req[2]), .fan_drive_1(fd[0]),
      .fan_drive_2(fd[1]), .fan_drive_3(fd[2]), .cpu1_domain_count(dom),
      .swap_active(swp), .cpu_read_start(crs), .cpu_fan_start(cfs),
      .remote1_fan_start(rfs), .reading_update(upd));
   // ----------------------------------------
   // clock, timeout and reporting
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task report_and_stop;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 65000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // ----------------------------------------
   // apb transfers
   // ----------------------------------------
   task apb(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_en;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd);
   endtask : wr
   task rdchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp);
   endtask : rdchk
   task wait_upd;
      n = 0;
      @(posedge sys_clk);
      while (upd !== 1'b1) begin
         @(posedge sys_clk);
         n++;
      end
   endtask : wait_upd
   task wait_crs;
      n = 0;
      @(posedge sys_clk);
      n++;
      while (crs !== 1'b1) begin
         @(posedge sys_clk);
         n++;
      end
   endtask : wait_crs
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      bitc = 16'h0001;
      ncpu = 2'h0;
      for (int i = 0; i < 3; i++) req[i] = 8'h80 + 8'(i);
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      rdchk(`PFC_IDX_CPU_CFG, `PFC_RST_CPU_CFG);
      rdchk(`PFC_IDX_START_THR, `PFC_RST_START_THR);
      rdchk(`PFC_IDX_CPU_READING, `PFC_RST_READING);
      apb(1'b0, 8'h01, 32'h0);
      chk(32'(err), 32'h1);
      chk(rd, 32'h0);
      wr(`PFC_IDX_CPU_CFG, 32'hFF);
      rdchk(`PFC_IDX_CPU_CFG, 32'h1F);
      chk(32'(dom), 32'h1);
      wr(`PFC_IDX_CPU_CFG, 32'h00);
      repeat (2) @(posedge sys_clk);
      chk(32'(dom), 32'h0);
      for (int i = 0; i < 3; i++) begin
         rdchk(`PFC_IDX_DUTY1 + 8'(i), `PFC_RST_DUTY);
         chk(32'(fd[i]), 32'h80 + i);
         wr(`PFC_IDX_DUTY1 + 8'(i), 32'h40 + i);
         repeat (3) @(posedge sys_clk);
         chk(32'(fd[i]), 32'h40 + i);
      end
      wait_upd();
      wait_upd();
      chk(n + 1, 16 * (`PFC_BITS_PER_READ + `PFC_IDLE_CYCLES));
      rdchk(`PFC_IDX_CPU_READING, 32'hF6);
      rdchk(`PFC_IDX_REMOTE1, 32'h2A);
      repeat (3) @(posedge sys_clk);
      chk(32'(cfs), 32'h1);
      wr(`PFC_IDX_START_THR, 32'h00);
      repeat (3) @(posedge sys_clk);
      chk(32'(cfs), 32'h0);
      wr(`PFC_IDX_START_THR, 32'hE0);
      wr(`PFC_IDX_CPU_CFG, 32'h10);
      rdchk(`PFC_IDX_REMOTE1, 32'hF6);
      rdchk(`PFC_IDX_CPU_READING, 32'h2A);
      repeat (3) @(posedge sys_clk);
      chk(32'(rfs), 32'h1);
      chk(32'(swp), 32'h1);
      chk(32'(cfs), 32'h0);
      wr(`PFC_IDX_GEN_CFG1, 32'h02);
      wr(`PFC_IDX_CPU_CFG, 32'h08);
      rdchk(`PFC_IDX_CPU_CFG, 32'h10);
      wr(`PFC_IDX_DUTY1, 32'hFF);
      rdchk(`PFC_IDX_DUTY1, 32'h40);
      wr(`PFC_IDX_START_THR, 32'h55);
      rdchk(`PFC_IDX_START_THR, 32'hE0);
      rdchk(`PFC_IDX_GEN_CFG1, 32'h02);
      // two cpus at two clocks per bit, changed just after a read start
      wait_crs();
      bitc <= 16'h0002;
      ncpu <= 2'h1;
      wait_crs();
      wait_crs();
      chk(n, `PFC_BITS_PER_READ * 2 * 2 + `PFC_IDLE_CYCLES);
      // mid-run reset clears lock and restores defaults
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      rdchk(`PFC_IDX_CPU_CFG, `PFC_RST_CPU_CFG);
      rdchk(`PFC_IDX_DUTY1, `PFC_RST_DUTY);
      rdchk(`PFC_IDX_GEN_CFG1, 32'h00);
      wr(`PFC_IDX_START_THR, 32'h55);
      rdchk(`PFC_IDX_START_THR, 32'h55);
      report_and_stop();
   end
endmodule : pfc_regs_tb
